/* File: hdl/sdic_pkg.sv */
// Package of constants for the serial DAC input control block
package sdic_pkg;
   // ==========================================================
   // Widths and reset values
   localparam int DATA_W = 12;
   localparam logic [11:0] DAC_RESET = 12'h000;
   localparam logic [11:0] SR_RESET = 12'h000;
   localparam logic [11:0] DAC_CLEAR = 12'h000;
   // Synchroniser reset: clear_n, load_n, sdata, sclk from top bit down
   localparam logic [3:0] SYNC_RESET = 4'hD;
   localparam logic SCLK_PREV_RESET = 1'h1;
   // ==========================================================
   // Link timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SYNC_STAGES = 2;
endpackage : sdic_pkg

/* File: hdl/sdic_sync_if.sv */
// Interface carrying synchronised pin levels
`timescale 1ns/1ps
interface sdic_sync_if;
   logic sclk;
   logic sdata;
   logic load_n;
   logic clear_n;
   modport src (output sclk, output sdata, output load_n, output clear_n);
   modport dst (input sclk, input sdata, input load_n, input clear_n);
endinterface : sdic_sync_if

/* File: hdl/sdic_sync.sv */
// Two-flop synchronisers for the serial link pins
`timescale 1ns/1ps
module sdic_sync (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [3:0] pins,
   sdic_sync_if.src out
);
   // ==========================================================
   // Synchroniser chain
   logic [3:0] stage1;
   logic [3:0] stage2;
   logic [3:0] next_stage1;
   logic [3:0] next_stage2;

   always_comb begin
      next_stage1 = pins;
      next_stage2 = stage1;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         stage1 <= sdic_pkg::SYNC_RESET;
         stage2 <= sdic_pkg::SYNC_RESET;
      end else begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end

   assign out.sclk = stage2[0];
   assign out.sdata = stage2[1];
   assign out.load_n = stage2[2];
   assign out.clear_n = stage2[3];
endmodule : sdic_sync

/* File: hdl/sdic_top.sv */
// Serial DAC input control: shift register and DAC register
// Function
// - With clear and load both high, each rising link clock edge shifts serial_in in, DAC holds.
// - With load low and clear high, the DAC register follows the shift register, shifting stops.
// - While clear is low the DAC register is zero and the shift register is untouched.
// - Clear rising with load high leaves the DAC register at zero and the shift register intact.
// - Clear rising with load low reloads the DAC register from the held shift register.
// - With load and clear high the DAC register holds, changing only by load or clear.
// - Words go most significant bit first, so the last bit lands in the lowest position.
`timescale 1ns/1ps
module sdic_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SCLK,
   input wire logic SERIAL_IN,
   input wire logic LOAD_STROBE_N,
   input wire logic CLEAR_N,
   output logic [11:0] DAC_VALUE,
   output logic [11:0] SHIFT_VALUE
);
   // ==========================================================
   // Pin synchronisation
   sdic_sync_if sync ();

   sdic_sync u_sync (
      .CLK(CLK),
      .RST_N(RST_N),
      .pins({CLEAR_N, LOAD_STROBE_N, SERIAL_IN, SCLK}),
      .out(sync.src)
   );

   // ==========================================================
   // Link clock edge detection
   logic sclk_prev;
   logic next_sclk_prev;
   logic sclk_rise;

   assign sclk_rise = sync.sclk & ~sclk_prev;

   // ==========================================================
   // Shift and DAC registers
   logic [11:0] shift_reg;
   logic [11:0] dac_reg;
   logic [11:0] next_shift_reg;
   logic [11:0] next_dac_reg;

   always_comb begin
      next_sclk_prev = sync.sclk;
      next_shift_reg = shift_reg;
      next_dac_reg = dac_reg;
      if (sclk_rise && sync.load_n && sync.clear_n) begin
         // Oldest bit drops off the top
         next_shift_reg = {shift_reg[10:0], sync.sdata};
      end
      if (!sync.clear_n) begin
         next_dac_reg = sdic_pkg::DAC_CLEAR;
      end else if (!sync.load_n) begin
         next_dac_reg = shift_reg;
      end
      // Otherwise the DAC register holds
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         // Matches synchroniser reset level, so no false edge after reset
         sclk_prev <= sdic_pkg::SCLK_PREV_RESET;
         shift_reg <= sdic_pkg::SR_RESET;
         dac_reg <= sdic_pkg::DAC_RESET;
      end else begin
         sclk_prev <= next_sclk_prev;
         shift_reg <= next_shift_reg;
         dac_reg <= next_dac_reg;
      end
   end

   assign DAC_VALUE = dac_reg;
   assign SHIFT_VALUE = shift_reg;

   // ==========================================================
   // Assertions
   property p_shift;
      @(posedge CLK) disable iff (!RST_N)
      (sclk_rise && sync.load_n && sync.clear_n) |=>
         shift_reg == {$past(shift_reg[10:0]), $past(sync.sdata)};
   endproperty
   a_shift: assert property (p_shift) else $error("Shift not taken");

   property p_rise_edge;
      @(posedge CLK) disable iff (!RST_N)
      sclk_rise |-> !$past(sync.sclk);
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("False link clock edge");

   property p_load;
      @(posedge CLK) disable iff (!RST_N)
      (!sync.load_n && sync.clear_n) |=> dac_reg == $past(shift_reg);
   endproperty
   a_load: assert property (p_load) else $error("DAC not loaded");

   property p_noshift_load;
      @(posedge CLK) disable iff (!RST_N)
      (!sync.load_n) |=> $stable(shift_reg);
   endproperty
   a_noshift_load: assert property (p_noshift_load) else $error("Shift while loading");

   property p_clear;
      @(posedge CLK) disable iff (!RST_N)
      (!sync.clear_n) |=> (dac_reg == 12'h000) && $stable(shift_reg);
   endproperty
   a_clear: assert property (p_clear) else $error("Clear failed");

   property p_clear_latch;
      @(posedge CLK) disable iff (!RST_N)
      (!sync.clear_n ##1 (sync.clear_n && sync.load_n)) |=> dac_reg == 12'h000;
   endproperty
   a_clear_latch: assert property (p_clear_latch) else $error("Zero not kept");

   property p_clear_reload;
      @(posedge CLK) disable iff (!RST_N)
      (!sync.clear_n ##1 (sync.clear_n && !sync.load_n)) |=> dac_reg == $past(shift_reg);
   endproperty
   a_clear_reload: assert property (p_clear_reload) else $error("No reload");

   property p_hold;
      @(posedge CLK) disable iff (!RST_N)
      (sync.load_n && sync.clear_n) |=> $stable(dac_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("DAC changed");

   property p_lsb;
      @(posedge CLK) disable iff (!RST_N)
      (sclk_rise && sync.load_n && sync.clear_n) |=> shift_reg[0] == $past(sync.sdata);
   endproperty
   a_lsb: assert property (p_lsb) else $error("Last bit not in LSB");

   property p_drop;
      @(posedge CLK) disable iff (!RST_N)
      (sclk_rise && sync.load_n && sync.clear_n) |=> shift_reg[11] == $past(shift_reg[10]);
   endproperty
   a_drop: assert property (p_drop) else $error("Top bit wrong");
endmodule : sdic_top

/* File: test/sdic_host.sv */
// Host model driving link, load strobe and clear
`timescale 1ns/1ps
module sdic_host (
   input wire logic CLK,
   output logic SCLK = 1'b0,
   output logic SERIAL_IN = 1'b1,
   output logic LOAD_STROBE_N = 1'b1,
   output logic CLEAR_N = 1'b1
);
   // Twelve bits, MSB first, link clock idle low between words
   task automatic send(input logic [11:0] w);
      for (int i = 11; i >= 0; i--) begin
         @(negedge CLK);
         SERIAL_IN = w[i];
         repeat (3) @(negedge CLK);
         SCLK = 1'b1;
         repeat (4) @(negedge CLK);
         SCLK = 1'b0;
      end
      repeat (2) @(negedge CLK);
      SERIAL_IN = ~SERIAL_IN;
      repeat (6) @(negedge CLK);
   endtask : send
   // Control levels change with the link clock idle
   task automatic ctl(input logic ld_n, input logic clr_n);
      @(negedge CLK);
      LOAD_STROBE_N = ld_n;
      CLEAR_N = clr_n;
      repeat (6) @(negedge CLK);
   endtask : ctl
endmodule : sdic_host

/* File: test/tb.sv */
// Testbench for the serial DAC input control block
`timescale 1ns/1ps
module tb;
   logic clk, rst_n, sclk, serial_in, ld_n, clr_n;
   logic [11:0] dac, shift, w, d;
   logic [31:0] seed = 32'h0080;
   int mismatches = 0;
   int tests_run = 0;
   sdic_top u_dut (.CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SERIAL_IN(serial_in),
      .LOAD_STROBE_N(ld_n), .CLEAR_N(clr_n), .DAC_VALUE(dac), .SHIFT_VALUE(shift));
   sdic_host u_host (.CLK(clk), .SCLK(sclk), .SERIAL_IN(serial_in), .LOAD_STROBE_N(ld_n),
      .CLEAR_N(clr_n));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #200000;
      mismatches++;
      results();
   end
   initial begin
      rst_n = 1'b0;
      d = 12'h000;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         w = (i == 0) ? 12'hFFF : seed[11:0];
         u_host.send(w);
         chk(shift, w);
         chk(dac, d);
         u_host.ctl(1'b0, 1'b1);
         d = w;
         chk(dac, d);
         u_host.send(~w);
         chk(shift, w);
         u_host.ctl(1'b1, 1'b1);
         chk(dac, d);
         if (i[0]) begin
            u_host.ctl(1'b1, 1'b0);
            chk(dac, 12'h000);
            u_host.send(~w);
            chk(shift, w);
            u_host.ctl(1'b1, 1'b1);
            chk(dac, 12'h000);
            chk(shift, w);
            d = 12'h000;
         end else begin
            u_host.ctl(1'b0, 1'b1);
            u_host.ctl(1'b0, 1'b0);
            chk(dac, 12'h000);
            u_host.ctl(1'b0, 1'b1);
            chk(dac, w);
            u_host.ctl(1'b1, 1'b1);
         end
      end
      results();
   end
endmodule : tb
